// file: logic/mrpc_defs.svh
`ifndef MRPC_DEFS_SVH
`define MRPC_DEFS_SVH

// register offsets
`define MRPC_OFF_X_LOW      7'h03
`define MRPC_OFF_Y_LOW      7'h04
`define MRPC_OFF_HIGH       7'h0C
`define MRPC_OFF_CTRL       7'h0D
`define MRPC_OFF_RUN_TO     7'h0E
`define MRPC_OFF_R1_INT     7'h0F
`define MRPC_OFF_R1_TO      7'h10
`define MRPC_OFF_R2_INT     7'h11
`define MRPC_OFF_R2_TO      7'h12
`define MRPC_OFF_R3_INT     7'h13
`define MRPC_OFF_OVR        7'h22

// reset values
`define MRPC_RST_HIGH       8'h00
`define MRPC_RST_CTRL       8'h01
`define MRPC_RST_RUN_TO     8'h08
`define MRPC_RST_R1_INT     8'h01
`define MRPC_RST_R1_TO      8'h1F
`define MRPC_RST_R2_INT     8'h09
`define MRPC_RST_R2_TO      8'h2F
`define MRPC_RST_R3_INT     8'h31
`define MRPC_RST_OVR        3'h0

// sensor_control fields; bit 6 is reserved and reads zero
`define MRPC_CTRL_MASK      8'hBF
`define MRPC_CTRL_WIDTH     7
`define MRPC_CTRL_RESOLUTION_FIELD_ENABLE    5
`define MRPC_CTRL_RES_MSB   4
`define MRPC_CTRL_RES_LSB   2
`define MRPC_CTRL_PD        1
`define MRPC_CTRL_LEGACY    0

// mode_override field
`define MRPC_OVR_MSB        6
`define MRPC_OVR_LSB        4
`define MRPC_FORCE_NORMAL   3'h0
`define MRPC_FORCE_FIRST_REST_STATE    3'h1
`define MRPC_FORCE_SECOND_REST_STATE    3'h2
`define MRPC_FORCE_THIRD_REST_STATE    3'h3
`define MRPC_FORCE_RUN1     3'h4
`define MRPC_FORCE_RUN2     3'h5
`define MRPC_FORCE_IDLE     3'h6

// rest interval bounds
`define MRPC_INT_MIN        8'h01
`define MRPC_INT_MAX        8'hFD

// downshift multipliers as shifts: 8, 16, 128
`define MRPC_RUN_SHIFT      3
`define MRPC_R1_SHIFT       4
`define MRPC_R2_SHIFT       7

// counts per inch
`define MRPC_CPI_250        12'h0FA
`define MRPC_CPI_500        12'h1F4
`define MRPC_CPI_1000       12'h3E8
`define MRPC_CPI_1250       12'h4E2
`define MRPC_CPI_1500       12'h5DC
`define MRPC_CPI_1750       12'h6D6
`define MRPC_CPI_2000       12'h7D0

// timing
`define MRPC_CLK_MHZ        250
`define MRPC_RUN_PERIOD_US  4000
`define MRPC_SLOW_TICK_MS   10

`endif

// file: logic/mrpc_pkg.sv
`include "mrpc_defs.svh"

package mrpc_pkg;

  typedef enum logic [5:0] {
    st_run1  = 6'b000001,
    st_run2  = 6'b000010,
    st_first_rest_state = 6'b000100,
    st_second_rest_state = 6'b001000,
    st_third_rest_state = 6'b010000,
    st_idle  = 6'b100000
  } mrpc_state_t;

  typedef logic [11:0] mrpc_disp_t;

  // saturating signed add of two 12-bit quantities
  function automatic mrpc_disp_t mrpc_sat_add(input mrpc_disp_t a, input mrpc_disp_t d);
    logic [12:0] s;
    s = {a[11], a} + {d[11], d};
    if (s[12] != s[11])
      mrpc_sat_add = s[12] ? 12'h800 : 12'h7FF;
    else
      mrpc_sat_add = s[11:0];
  endfunction : mrpc_sat_add

  // clip a 12-bit value into the 8-bit range, sign extended
  function automatic mrpc_disp_t mrpc_clip8(input mrpc_disp_t a);
    if (!a[11] && a[10:7] != 4'h0)
      mrpc_clip8 = 12'h07F;
    else if (a[11] && a[10:7] != 4'hF)
      mrpc_clip8 = 12'hF80;
    else
      mrpc_clip8 = a;
  endfunction : mrpc_clip8

  // resolution field to counts per inch; code 7 falls back to 1000
  function automatic logic [11:0] mrpc_cpi(input logic [2:0] f);
    case (f)
      3'h0:    mrpc_cpi = `MRPC_CPI_1000;
      3'h1:    mrpc_cpi = `MRPC_CPI_250;
      3'h2:    mrpc_cpi = `MRPC_CPI_500;
      3'h3:    mrpc_cpi = `MRPC_CPI_1250;
      3'h4:    mrpc_cpi = `MRPC_CPI_1500;
      3'h5:    mrpc_cpi = `MRPC_CPI_1750;
      3'h6:    mrpc_cpi = `MRPC_CPI_2000;
      default: mrpc_cpi = `MRPC_CPI_1000;
    endcase
  endfunction : mrpc_cpi

endpackage : mrpc_pkg

// file: logic/mrpc_tick_gen.sv
`timescale 1ns/1ns

// free running divider: one-cycle tick every PERIOD clocks while enabled
module mrpc_tick_gen #(
  parameter int unsigned PERIOD = 1000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control and output
  input  wire logic enable,
  output logic      tick
);

  localparam int unsigned W = $clog2(PERIOD + 1);

  logic [W-1:0] count_reg;

  // restart from zero when disabled so a wake gives a full period
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_reg <= '0;
      tick      <= 1'b0;
    end
    else if (!enable)
    begin
      count_reg <= '0;
      tick      <= 1'b0;
    end
    else if (count_reg == W'(PERIOD - 1))
    begin
      count_reg <= '0;
      tick      <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + W'(1);
      tick      <= 1'b0;
    end
  end

endmodule : mrpc_tick_gen

// file: logic/mrpc_top.sv
`timescale 1ns/1ns
`include "mrpc_defs.svh"

// Notes on behaviour
// RULE1: high-nibble register bits 7:4 carry the top four bits of X.
// RULE2: high-nibble register bits 3:0 carry the top four bits of Y.
// RULE3: 12-bit X and Y are two's complement, nibble MSB is sign.
// RULE4: controller reads low X, low Y, high nibbles back to back.
// RULE5: control bit 7 picks 8-bit or 12-bit motion reports.
// RULE6: control bit 5 set takes resolution from field bits 4:2.
// RULE7: field codes 0..6 mean 1000,250,500,1250,1500,1750,2000 cpi.
// RULE8: control bit 0 picks 500 or 1250 cpi, ignored when bit 5 set.
// RULE9: run drops to first rest after timeout times 8 run periods idle.
// RULE10: rest interval is (value+1) slow ticks, value kept 0x01..0xFD.
// RULE11: first rest drops to second after timeout times interval times 16.
// RULE12: second rest drops to third after timeout times interval times 128.
// RULE13: controller forces run around timing writes, then releases override.
// RULE14: override field 6:4 forces normal, rest 1-3, run 1-2 or idle.
// RULE15: nibbles and low bytes come from one motion snapshot.
// RULE16: power-down bit halts frames and motion accumulation.
module mrpc_top #(
  parameter int unsigned RUN_PERIOD_CYC = `MRPC_RUN_PERIOD_US * `MRPC_CLK_MHZ,
  parameter int unsigned SLOW_TICK_CYC  = `MRPC_SLOW_TICK_MS * 1000 * `MRPC_CLK_MHZ
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register access from the serial port engine
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // per-frame displacement from the motion estimator
  input  wire logic        motion_valid,
  input  wire logic [11:0] motion_dx,
  input  wire logic [11:0] motion_dy,
  // power and acquisition control
  output logic             frame_start,
  output logic             power_down,
  output logic             report_12bit,
  output logic      [5:0]  power_state,
  output logic      [11:0] cpi_setting
);

  logic [7:0]            ctrl_reg;
  logic [7:0]            run_to_reg;
  logic [7:0]            r1_int_reg;
  logic [7:0]            r1_to_reg;
  logic [7:0]            r2_int_reg;
  logic [7:0]            r2_to_reg;
  logic [7:0]            r3_int_reg;
  logic [2:0]            ovr_reg;
  mrpc_pkg::mrpc_disp_t  acc_x_reg;
  mrpc_pkg::mrpc_disp_t  acc_y_reg;
  mrpc_pkg::mrpc_disp_t  snap_x_reg;
  mrpc_pkg::mrpc_disp_t  snap_y_reg;
  mrpc_pkg::mrpc_disp_t  x_rep;
  mrpc_pkg::mrpc_disp_t  y_rep;
  mrpc_pkg::mrpc_state_t state_reg;
  mrpc_pkg::mrpc_state_t state_next;
  logic [14:0]           dwell_cnt_reg;
  logic [7:0]            int_cnt_reg;
  logic [7:0]            eff_int;
  logic [14:0]           limit;
  logic                  pd;
  logic                  take_snap;
  logic                  motion_seen;
  logic                  run_tick;
  logic                  slow_tick;
  logic                  frame_now;
  logic                  forced;

  assign pd        = ctrl_reg[`MRPC_CTRL_PD];
  assign take_snap = reg_rd && (reg_addr == `MRPC_OFF_X_LOW); // [RULE4]
  assign forced    = (ovr_reg != `MRPC_FORCE_NORMAL) && (ovr_reg != 3'h7);
  assign motion_seen = motion_valid && !pd && ((motion_dx != 12'h000) || (motion_dy != 12'h000));

  // what a snapshot would hold: clipped to 8 bits unless wide reports
  assign x_rep = ctrl_reg[`MRPC_CTRL_WIDTH] ? acc_x_reg : mrpc_pkg::mrpc_clip8(acc_x_reg); // [RULE5]
  assign y_rep = ctrl_reg[`MRPC_CTRL_WIDTH] ? acc_y_reg : mrpc_pkg::mrpc_clip8(acc_y_reg);

  // tick sources; both stop in power-down so nothing runs on
  mrpc_tick_gen #(.PERIOD(RUN_PERIOD_CYC)) u_run_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (!pd),
    .tick    (run_tick)
  );

  mrpc_tick_gen #(.PERIOD(SLOW_TICK_CYC)) u_slow_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (!pd),
    .tick    (slow_tick)
  );

  // register writes; reserved bits never stored
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_reg   <= `MRPC_RST_CTRL;
      run_to_reg <= `MRPC_RST_RUN_TO;
      r1_int_reg <= `MRPC_RST_R1_INT;
      r1_to_reg  <= `MRPC_RST_R1_TO;
      r2_int_reg <= `MRPC_RST_R2_INT;
      r2_to_reg  <= `MRPC_RST_R2_TO;
      r3_int_reg <= `MRPC_RST_R3_INT;
      ovr_reg    <= `MRPC_RST_OVR;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `MRPC_OFF_CTRL:   ctrl_reg   <= reg_wdata & `MRPC_CTRL_MASK;
        `MRPC_OFF_RUN_TO: run_to_reg <= reg_wdata;
        `MRPC_OFF_R1_INT: r1_int_reg <= reg_wdata;
        `MRPC_OFF_R1_TO:  r1_to_reg  <= reg_wdata;
        `MRPC_OFF_R2_INT: r2_int_reg <= reg_wdata;
        `MRPC_OFF_R2_TO:  r2_to_reg  <= reg_wdata;
        `MRPC_OFF_R3_INT: r3_int_reg <= reg_wdata;
        `MRPC_OFF_OVR:    ovr_reg    <= reg_wdata[`MRPC_OVR_MSB:`MRPC_OVR_LSB];
        default: ;
      endcase
    end
  end

  // accumulate until the low X read; motion in that same cycle is kept
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_x_reg <= 12'h000;
      acc_y_reg <= 12'h000;
    end
    else
    begin
      if (motion_valid && !pd) // [RULE16]
      begin
        acc_x_reg <= mrpc_pkg::mrpc_sat_add(take_snap ? 12'h000 : acc_x_reg, motion_dx); // [RULE3]
        acc_y_reg <= mrpc_pkg::mrpc_sat_add(take_snap ? 12'h000 : acc_y_reg, motion_dy);
      end
      else if (take_snap)
      begin
        acc_x_reg <= 12'h000;
        acc_y_reg <= 12'h000;
      end
    end
  end

  // one snapshot feeds both low bytes and the nibble register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      snap_x_reg <= 12'h000;
      snap_y_reg <= 12'h000;
    end
    else if (take_snap)
    begin
      snap_x_reg <= x_rep; // [RULE15]
      snap_y_reg <= y_rep;
    end
  end

  // read data, registered; unmapped offsets read zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `MRPC_OFF_X_LOW:  reg_rdata <= x_rep[7:0];
        `MRPC_OFF_Y_LOW:  reg_rdata <= snap_y_reg[7:0];
        `MRPC_OFF_HIGH:   reg_rdata <= {snap_x_reg[11:8], snap_y_reg[11:8]}; // [RULE1] [RULE2]
        `MRPC_OFF_CTRL:   reg_rdata <= ctrl_reg;
        `MRPC_OFF_RUN_TO: reg_rdata <= run_to_reg;
        `MRPC_OFF_R1_INT: reg_rdata <= r1_int_reg;
        `MRPC_OFF_R1_TO:  reg_rdata <= r1_to_reg;
        `MRPC_OFF_R2_INT: reg_rdata <= r2_int_reg;
        `MRPC_OFF_R2_TO:  reg_rdata <= r2_to_reg;
        `MRPC_OFF_R3_INT: reg_rdata <= r3_int_reg;
        `MRPC_OFF_OVR:    reg_rdata <= {1'b0, ovr_reg, 4'h0};
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // resolution select
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cpi_setting <= `MRPC_CPI_1250;
    else if (ctrl_reg[`MRPC_CTRL_RESOLUTION_FIELD_ENABLE])
      cpi_setting <= mrpc_pkg::mrpc_cpi(ctrl_reg[`MRPC_CTRL_RES_MSB:`MRPC_CTRL_RES_LSB]); // [RULE6] [RULE7]
    else
      cpi_setting <= ctrl_reg[`MRPC_CTRL_LEGACY] ? `MRPC_CPI_1250 : `MRPC_CPI_500; // [RULE8]
  end

  // interval of the current rest state, held inside the legal range
  always_comb
  begin
    case (state_reg)
      mrpc_pkg::st_first_rest_state: eff_int = r1_int_reg;
      mrpc_pkg::st_second_rest_state: eff_int = r2_int_reg;
      default:            eff_int = r3_int_reg;
    endcase
    if (eff_int < `MRPC_INT_MIN)
      eff_int = `MRPC_INT_MIN; // [RULE10]
    else if (eff_int > `MRPC_INT_MAX)
      eff_int = `MRPC_INT_MAX;
  end

  // frames: every run tick in run, every (interval+1) slow ticks in rest
  always_comb
  begin
    case (state_reg)
      mrpc_pkg::st_run1,
      mrpc_pkg::st_run2:  frame_now = run_tick;
      mrpc_pkg::st_first_rest_state,
      mrpc_pkg::st_second_rest_state,
      mrpc_pkg::st_third_rest_state: frame_now = slow_tick && (int_cnt_reg == eff_int); // [RULE10]
      default:            frame_now = 1'b0;
    endcase
  end

  // downshift thresholds in frames; a zero timeout acts as one
  always_comb
  begin
    case (state_reg)
      mrpc_pkg::st_run1:
        limit = {4'h0, (run_to_reg == 8'h00) ? 8'h01 : run_to_reg, 3'h0}; // [RULE9]
      mrpc_pkg::st_first_rest_state:
        limit = {3'h0, (r1_to_reg == 8'h00) ? 8'h01 : r1_to_reg, 4'h0}; // [RULE11]
      default:
        limit = {(r2_to_reg == 8'h00) ? 8'h01 : r2_to_reg, 7'h00}; // [RULE12]
    endcase
  end

  // power state: override first, then motion wake, then downshift
  always_comb
  begin
    state_next = state_reg;
    if (forced)
    begin
      case (ovr_reg)
        `MRPC_FORCE_FIRST_REST_STATE: state_next = mrpc_pkg::st_first_rest_state; // [RULE14]
        `MRPC_FORCE_SECOND_REST_STATE: state_next = mrpc_pkg::st_second_rest_state;
        `MRPC_FORCE_THIRD_REST_STATE: state_next = mrpc_pkg::st_third_rest_state;
        `MRPC_FORCE_RUN1:  state_next = mrpc_pkg::st_run1;
        `MRPC_FORCE_RUN2:  state_next = mrpc_pkg::st_run2;
        default:           state_next = mrpc_pkg::st_idle;
      endcase
    end
    else if (motion_seen || state_reg == mrpc_pkg::st_run2 || state_reg == mrpc_pkg::st_idle)
      state_next = mrpc_pkg::st_run1;
    else if (frame_now && (15'(dwell_cnt_reg + 15'h0001) >= limit))
    begin
      case (state_reg)
        mrpc_pkg::st_run1:  state_next = mrpc_pkg::st_first_rest_state; // [RULE9]
        mrpc_pkg::st_first_rest_state: state_next = mrpc_pkg::st_second_rest_state; // [RULE11]
        mrpc_pkg::st_second_rest_state: state_next = mrpc_pkg::st_third_rest_state; // [RULE12]
        default:            state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= mrpc_pkg::st_run1;
    else
      state_reg <= state_next;
  end

  // dwell counting is held at zero under override so timing writes are safe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dwell_cnt_reg <= 15'h0000;
    else if (forced || motion_seen || state_next != state_reg) // [RULE13]
      dwell_cnt_reg <= 15'h0000;
    else if (frame_now)
      dwell_cnt_reg <= 15'(dwell_cnt_reg + 15'h0001);
  end

  // slow ticks within the current rest interval
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      int_cnt_reg <= 8'h00;
    else if (state_next != state_reg)
      int_cnt_reg <= 8'h00;
    else if (slow_tick)
      int_cnt_reg <= (int_cnt_reg >= eff_int) ? 8'h00 : 8'(int_cnt_reg + 8'h01);
  end

  // outputs straight from flops
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      frame_start  <= 1'b0;
      power_down   <= 1'b0;
      report_12bit <= 1'b0;
      power_state  <= 6'h01;
    end
    else
    begin
      frame_start  <= frame_now && !pd; // [RULE16]
      power_down   <= pd;
      report_12bit <= ctrl_reg[`MRPC_CTRL_WIDTH]; // [RULE5]
      power_state  <= state_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_hi_read;
    reg_rd && reg_addr == `MRPC_OFF_HIGH;
  endsequence

  sequence s_run_expire;
    state_reg == mrpc_pkg::st_run1 && !forced && !motion_seen && frame_now
      && (15'(dwell_cnt_reg + 15'h0001) >= limit);
  endsequence

  a_x_nibble_read: assert property (s_hi_read |=> reg_rdata[7:4] == $past(snap_x_reg[11:8])) // [RULE1]
    else $error("x nibble mismatch");
  a_y_nibble_read: assert property (s_hi_read |=> reg_rdata[3:0] == $past(snap_y_reg[11:8])) // [RULE2]
    else $error("y nibble mismatch");
  a_narrow_sign_ext: assert property (take_snap && !ctrl_reg[7] |=> // [RULE3]
      snap_x_reg[11:7] == {5{snap_x_reg[7]}} && snap_y_reg[11:7] == {5{snap_y_reg[7]}})
    else $error("8-bit snapshot not sign extended");
  a_width_flag: assert property (##1 report_12bit == $past(ctrl_reg[7])) // [RULE5]
    else $error("report width flag wrong");
  a_cpi_field: assert property (ctrl_reg[5] && ctrl_reg[4:2] == 3'h1 |=> cpi_setting == 12'h0FA) // [RULE7]
    else $error("resolution field decode wrong");
  a_cpi_legacy: assert property (!ctrl_reg[5] && ctrl_reg[0] |=> cpi_setting == 12'h4E2) // [RULE8]
    else $error("legacy resolution wrong");
  a_run_downshift: assert property (s_run_expire |=> state_reg == mrpc_pkg::st_first_rest_state) // [RULE9]
    else $error("run downshift missed");
  a_rest_frame: assert property (state_reg == mrpc_pkg::st_first_rest_state && state_next == state_reg
      && slow_tick && int_cnt_reg == eff_int && !pd |=> frame_start ##1 !frame_start) // [RULE10]
    else $error("rest frame missing");
  a_first_rest_state_hold: assert property (state_reg == mrpc_pkg::st_first_rest_state && !forced && !motion_seen
      && frame_now && 15'(dwell_cnt_reg + 15'h0001) < limit |=> state_reg == mrpc_pkg::st_first_rest_state) // [RULE11]
    else $error("early downshift from first rest");
  a_second_rest_state_shift: assert property (state_reg == mrpc_pkg::st_second_rest_state && !forced && !motion_seen
      && frame_now && dwell_cnt_reg + 15'h0001 == limit |=> state_reg == mrpc_pkg::st_third_rest_state) // [RULE12]
    else $error("second rest downshift missed");
  a_force_idle: assert property (ovr_reg == 3'h6 |=> state_reg == mrpc_pkg::st_idle ##1 !frame_start) // [RULE14]
    else $error("forced idle not honoured");
  a_snap_clears: assert property (take_snap && !motion_valid |=> acc_x_reg == 12'h000 // [RULE15]
      && acc_y_reg == 12'h000 && snap_x_reg == $past(x_rep))
    else $error("snapshot not coherent");
  a_pd_halts: assert property (power_down |-> !frame_start) // [RULE16]
    else $error("frame while powered down");

endmodule : mrpc_top

// file: bench/mrpc_host_model.sv
`timescale 1ns/1ns

// controller side of the register port; strobes last one cycle
module mrpc_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [6:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    reg_addr  = 7'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one write; data inverted after so a stale value is never mistaken
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : write_reg

  // one read; answer lands on the edge that sees the strobe
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : read_reg

  // timing writes wrapped in forced run, value written as given
  task automatic timing_write(input logic [6:0] a, input logic [7:0] d);
    write_reg(7'h22, 8'h40);
    write_reg(a, d);
    write_reg(7'h22, 8'h00);
  endtask : timing_write

  // low x, low y, high nibbles with nothing in between
  task automatic read_motion(output logic [7:0] x, output logic [7:0] y, output logic [7:0] h);
    read_reg(7'h03, x);
    read_reg(7'h04, y);
    read_reg(7'h0C, h);
  endtask : read_motion
endmodule : mrpc_host_model

// file: bench/test_motion_report_power_config.sv
`timescale 1ns/1ns

// self-checking bench for the motion report and power configuration block
module test_motion_report_power_config;
  typedef struct {
    logic [6:0]  addr;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [11:0] cpi;
    logic        r12;
    logic        pd;
  } mrpc_row_t;
  // design ports
  logic        clk          = 1'b0;
  logic        sys_rst      = 1'b1;
  logic        motion_valid = 1'b0;
  logic [11:0] motion_dx    = 12'h000;
  logic [11:0] motion_dy    = 12'h000;
  logic [6:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        frame_start;
  logic        power_down;
  logic        report_12bit;
  logic [5:0]  power_state;
  logic [11:0] cpi_setting;
  int          num_errors   = 0;
  int          check_count  = 0;
  // write rows: timing registers first, then the nibble register, then control codes
  mrpc_row_t   rows [20] = '{
    '{7'h0E, 8'h01, 8'h01, 12'h4E2, 1'b0, 1'b0}, '{7'h0F, 8'h01, 8'h01, 12'h4E2, 1'b0, 1'b0},
    '{7'h10, 8'h01, 8'h01, 12'h4E2, 1'b0, 1'b0}, '{7'h11, 8'h01, 8'h01, 12'h4E2, 1'b0, 1'b0},
    '{7'h12, 8'h01, 8'h01, 12'h4E2, 1'b0, 1'b0}, '{7'h13, 8'h02, 8'h02, 12'h4E2, 1'b0, 1'b0},
    '{7'h0C, 8'hFF, 8'h00, 12'h4E2, 1'b0, 1'b0}, '{7'h0D, 8'h00, 8'h00, 12'h1F4, 1'b0, 1'b0},
    '{7'h0D, 8'h01, 8'h01, 12'h4E2, 1'b0, 1'b0}, '{7'h0D, 8'h20, 8'h20, 12'h3E8, 1'b0, 1'b0},
    '{7'h0D, 8'h25, 8'h25, 12'h0FA, 1'b0, 1'b0}, '{7'h0D, 8'h28, 8'h28, 12'h1F4, 1'b0, 1'b0},
    '{7'h0D, 8'h2C, 8'h2C, 12'h4E2, 1'b0, 1'b0}, '{7'h0D, 8'h30, 8'h30, 12'h5DC, 1'b0, 1'b0},
    '{7'h0D, 8'h35, 8'h35, 12'h6D6, 1'b0, 1'b0}, '{7'h0D, 8'h38, 8'h38, 12'h7D0, 1'b0, 1'b0},
    '{7'h0D, 8'hC0, 8'h80, 12'h1F4, 1'b1, 1'b0}, '{7'h0D, 8'h82, 8'h82, 12'h1F4, 1'b1, 1'b1},
    '{7'h0D, 8'h3C, 8'h3C, 12'h3E8, 1'b0, 1'b0}, '{7'h0D, 8'h01, 8'h01, 12'h4E2, 1'b0, 1'b0}};
  logic [6:0]  rst_addr [10] = '{7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h12, 7'h13,
                                 7'h22, 7'h30};
  logic [7:0]  rst_val  [10] = '{8'h00, 8'h01, 8'h08, 8'h01, 8'h1F, 8'h09, 8'h2F, 8'h31,
                                 8'h00, 8'h00};
  // releasing a forced rest keeps that rest; only run2 and idle fall back to run1
  logic [5:0]  ovr_state [7] = '{6'h04, 6'h04, 6'h08, 6'h10, 6'h01, 6'h02, 6'h20};

  // short frame and slow-tick periods keep the downshift run brief
  mrpc_top #(.RUN_PERIOD_CYC(4), .SLOW_TICK_CYC(3)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .motion_valid(motion_valid),
    .motion_dx(motion_dx), .motion_dy(motion_dy), .frame_start(frame_start),
    .power_down(power_down), .report_12bit(report_12bit), .power_state(power_state),
    .cpi_setting(cpi_setting));
  mrpc_host_model host_u (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // one frame of displacement
  task automatic move(input logic [11:0] dx, input logic [11:0] dy);
    @(posedge clk);
    motion_valid <= 1'b1;
    motion_dx    <= dx;
    motion_dy    <= dy;
    @(posedge clk);
    motion_valid <= 1'b0;
  endtask : move

  // bounded wait for a power state; n returns the cycles spent
  task automatic wait_state(input logic [5:0] s, input int lim, output int n);
    n = 0;
    while (power_state !== s && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_state

  task automatic count_frames(output int c);
    c = 0;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      if (frame_start === 1'b1)
        c++;
    end
  endtask : count_frames

  // watchdog: whole run needs about 1250 cycles
  initial
  begin
    #80000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] h;
    int         n;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("power_state", 12'h001, {6'h00, power_state});
    chk("cpi_setting", 12'h4E2, cpi_setting);
    chk("report_12bit", 12'h000, {11'h000, report_12bit});
    chk("power_down", 12'h000, {11'h000, power_down});
    for (int i = 0; i < 10; i++)
    begin
      host_u.read_reg(rst_addr[i], d);
      chk("reset_value", {4'h0, rst_val[i]}, {4'h0, d});
    end
    // table of writes, outputs and read-back
    foreach (rows[i])
    begin
      if (rows[i].addr == 7'h0D)
        host_u.write_reg(rows[i].addr, rows[i].wd);
      else
        host_u.timing_write(rows[i].addr, rows[i].wd);
      repeat (2) @(posedge clk);
      #1;
      chk("cpi_setting", rows[i].cpi, cpi_setting);
      chk("report_12bit", {11'h000, rows[i].r12}, {11'h000, report_12bit});
      chk("power_down", {11'h000, rows[i].pd}, {11'h000, power_down});
      host_u.read_reg(rows[i].addr, d);
      chk("read_back", {4'h0, rows[i].rd}, {4'h0, d});
    end
    // every override code, ending with normal
    for (int c = 6; c >= 0; c--)
    begin
      host_u.write_reg(7'h22, {1'b0, 3'(c), 4'h0});
      repeat (3) @(posedge clk);
      #1;
      chk("forced_state", {6'h00, ovr_state[c]}, {6'h00, power_state});
      host_u.read_reg(7'h22, d);
      chk("override_read", {5'h00, 3'(c), 4'h0}, {4'h0, d});
    end
    // code 7 is no force: the first_rest_state left by code 1 carries on
    host_u.write_reg(7'h22, 8'h70);
    repeat (3) @(posedge clk);
    #1;
    chk("override_7", 12'h004, {6'h00, power_state});
    // frames in forced run, none and no motion while powered down
    host_u.write_reg(7'h22, 8'h40);
    @(posedge clk); // first counted cycle already in forced run
    count_frames(n);
    chk("run_frames", 12'd5, 12'(n));
    host_u.write_reg(7'h0D, 8'h03);
    move(12'h005, 12'h005);
    count_frames(n);
    chk("pd_frames", 12'd0, 12'(n));
    host_u.write_reg(7'h0D, 8'h01);
    host_u.write_reg(7'h22, 8'h00);
    host_u.read_reg(7'h03, d);
    chk("pd_motion", 12'h000, {4'h0, d});
    // downshift chain: 8 run frames, 16 and 128 rest frames of 6 cycles
    move(12'h001, 12'h000);
    wait_state(6'h04, 200, n);
    chk("run_to_first_rest_state", 12'h001, {11'h000, n >= 28 && n <= 40});
    wait_state(6'h08, 300, n);
    chk("first_rest_state_to_second_rest_state", 12'h001, {11'h000, n >= 90 && n <= 110});
    wait_state(6'h10, 1000, n);
    chk("second_rest_state_to_third_rest_state", 12'h001, {11'h000, n >= 760 && n <= 790});
    wait_state(6'h10, 1, n);
    n = 0;
    while (frame_start !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (frame_start !== 1'b1 && n < 50);
    chk("third_rest_state_interval", 12'd9, 12'(n));
    move(12'h001, 12'h000);
    wait_state(6'h01, 5, n);
    chk("wake_state", 12'h001, {6'h00, power_state});
    // 12-bit snapshot over two frames, one negative axis
    host_u.read_motion(x, y, h);
    host_u.write_reg(7'h0D, 8'h80);
    move(12'h100, 12'hF80);
    move(12'h023, 12'h005);
    host_u.read_motion(x, y, h);
    chk("x_low", 12'h023, {4'h0, x});
    chk("y_low", 12'h085, {4'h0, y});
    chk("high_nibbles", 12'h01F, {4'h0, h});
    host_u.read_reg(7'h03, d);
    chk("x_cleared", 12'h000, {4'h0, d});
    // 8-bit reports clip and sign-extend
    host_u.write_reg(7'h0D, 8'h01);
    move(12'h123, 12'hF85);
    host_u.read_motion(x, y, h);
    chk("x_clip", 12'h07F, {4'h0, x});
    chk("y_8bit", 12'h085, {4'h0, y});
    chk("nibbles_8bit", 12'h00F, {4'h0, h});
    // reset in mid-run from a non-default setting brings everything back
    host_u.write_reg(7'h0D, 8'h82);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("rst_cpi", 12'h4E2, cpi_setting);
    chk("rst_report_12bit", 12'h000, {11'h000, report_12bit});
    chk("rst_power_down", 12'h000, {11'h000, power_down});
    host_u.read_reg(7'h0C, d);
    chk("rst_high_nibbles", 12'h000, {4'h0, d});
    complete_run();
  end
endmodule : test_motion_report_power_config
